// ===== hw/intc_pkg.sv
// Constants shared by the vectored interrupt unit
package intc_pkg;
    localparam int          ADDR_W        = 10;
    localparam int          N_SRC         = 6;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_PRIO      = 8'hf9;
    localparam logic [7:0]  IDX_FLAGS     = 8'hfa;
    localparam logic [7:0]  IDX_MASK      = 8'hfb;
    localparam logic [7:0]  IDX_CONFIG    = 8'hf0;
    localparam logic [7:0]  IDX_EVT_STAT  = 8'hf1;
    localparam logic [7:0]  IDX_EVT_MASK  = 8'hf2;
    // Reset values
    localparam logic [5:0]  FLAGS_RST     = 6'h00;
    localparam logic [1:0]  EDGE_RST      = 2'h0;
    localparam logic [7:0]  MASK_RST      = 8'h00;
    localparam logic [5:0]  PRIO_RST      = 6'h00;
    // Field positions
    localparam int          GLOBAL_EN_BIT = 7;
    localparam int          PROTECT_BIT   = 6;
    localparam int          REQ_ZERO      = 0;
    localparam int          REQ_ONE       = 1;
    localparam int          REQ_TWO       = 2;
    localparam int          REQ_T0        = 4;
    localparam int          REQ_T1        = 5;
    localparam int          EVT_GRANT     = 0;
    localparam int          EVT_BLOCK     = 1;
    // Protected upper general registers and AXI response codes
    localparam logic [7:0]  PROT_LO       = 8'h80;
    localparam logic [7:0]  PROT_HI       = 8'hef;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ===== hw/vectored_intc.sv
// Six-source vectored interrupt unit with AXI4-Lite registers
//
// Behaviour
// - Six requests: three port-3 lines, software request, two timers.
// - Mask register enables each request and, via bit 7, all globally.
// - Among enabled pending requests a programmable priority encoder picks one.
// - Grant starts machine cycle: global disable, core saves state, vector jump.
// - Vector of source n is the byte pair at 2n, 2n+1.
// - Request one sets only on a falling edge of port line three.
// - Requests latch even while masked; software polls the flag register.
// - Comparator one feeds request two, comparator two feeds request zero.
// - Requests zero and two trigger on rising, falling or both edges.
// - Edge selection lives in bits 7 and 6 of the flag register.
// - Code 00 FF, 01 line1 F line2 R, 10 line1 R line2 F, 11 both.
// - Mask bit 6 set blocks writes to registers 80h to EFh.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module vectored_intc
(
    // Clock and reset
    input  wire logic                          clk_sys_in,
    input  wire logic                          resetn_in,
    // AXI4-Lite slave
    input  wire logic [intc_pkg::ADDR_W-1:0]   s_axi_awaddr_in,
    input  wire logic                          s_axi_awvalid_in,
    output logic                               s_axi_awready_out,
    input  wire logic [31:0]                   s_axi_wdata_in,
    input  wire logic [3:0]                    s_axi_wstrb_in,
    input  wire logic                          s_axi_wvalid_in,
    output logic                               s_axi_wready_out,
    output logic [1:0]                         s_axi_bresp_out,
    output logic                               s_axi_bvalid_out,
    input  wire logic                          s_axi_bready_in,
    input  wire logic [intc_pkg::ADDR_W-1:0]   s_axi_araddr_in,
    input  wire logic                          s_axi_arvalid_in,
    output logic                               s_axi_arready_out,
    output logic [31:0]                        s_axi_rdata_out,
    output logic [1:0]                         s_axi_rresp_out,
    output logic                               s_axi_rvalid_out,
    input  wire logic                          s_axi_rready_in,
    // Request sources
    input  wire logic                          port3_line1_in,
    input  wire logic                          port3_line2_in,
    input  wire logic                          port3_line3_in,
    input  wire logic                          comparator_one_out_in,
    input  wire logic                          comparator_two_out_in,
    input  wire logic                          timer0_request_in,
    input  wire logic                          timer1_request_in,
    // Core sequencer
    input  wire logic                          cpu_ack_in,
    input  wire logic                          iret_in,
    output logic                               int_pending_out,
    output logic [7:0]                         vector_addr_out,
    output logic                               int_cycle_out,
    // Register file write guard
    input  wire logic                          ram_wr_req_in,
    input  wire logic [7:0]                    ram_wr_addr_in,
    output logic                               ram_wr_allow_out,
    // Interrupt to system
    output logic                               irq_out
);
    import intc_pkg::*;

    typedef struct packed {
        logic [2:0]  sync1_p;
        logic [2:0]  sync2_p;
        logic [2:0]  prev_p;
        logic [1:0]  sync1_c;
        logic [1:0]  sync2_c;
        logic [1:0]  prev_c;
        logic [5:0]  req;
        logic [1:0]  edge_sel;
        logic [7:0]  mask;
        logic [5:0]  prio;
        logic        analog;
        logic [1:0]  evt_stat;
        logic [1:0]  evt_mask;
        logic        aw_got;
        logic        w_got;
        logic [ADDR_W-1:0] aw_addr;
        logic [31:0] wdata;
        logic        wen;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        pending;
        logic [2:0]  src;
        logic        cycle;
        logic        ram_allow;
        logic        irq;
    } state_type;

    state_type state;
    state_type next_state;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == ADDR_W'({idx, 2'b00}));
    endfunction

    // Rotating pick: prio[2:0] names the source of highest rank
    function automatic logic [3:0] pick(input logic [5:0] p, input logic [2:0] base);
        logic [3:0] r;
        logic [2:0] s;
        r = 4'h0;
        for (int k = N_SRC - 1; k >= 0; k--)
        begin
            s = 3'((int'(base) + k) % N_SRC);
            if (p[s])
                r = {1'b1, s};
        end
        pick = r;
    endfunction

    logic [2:0] p_rise;
    logic [2:0] p_fall;
    logic [1:0] c_rise;
    logic [1:0] c_fall;
    logic       s0_r;
    logic       s0_f;
    logic       s2_r;
    logic       s2_f;
    logic [5:0] set_req;
    logic [3:0] choice;
    logic       blocked;
    logic       do_wr;
    logic [2:0] base;

    always_comb
    begin
        next_state = state;
        next_state.sync1_p = {port3_line3_in, port3_line2_in, port3_line1_in};
        next_state.sync2_p = state.sync1_p;
        next_state.prev_p = state.sync2_p;
        next_state.sync1_c = {comparator_two_out_in, comparator_one_out_in};
        next_state.sync2_c = state.sync1_c;
        next_state.prev_c = state.sync2_c;
        p_rise = state.sync2_p & ~state.prev_p;
        p_fall = ~state.sync2_p & state.prev_p;
        c_rise = state.sync2_c & ~state.prev_c;
        c_fall = ~state.sync2_c & state.prev_c;
        // Comparators take over lines one and two in analog mode
        s2_r = state.analog ? c_rise[0] : p_rise[0];
        s2_f = state.analog ? c_fall[0] : p_fall[0];
        s0_r = state.analog ? c_rise[1] : p_rise[1];
        s0_f = state.analog ? c_fall[1] : p_fall[1];
        set_req = 6'h00;
        set_req[REQ_TWO] = (state.edge_sel[1] & s2_r)
            | ((~state.edge_sel[1] | state.edge_sel[0]) & s2_f);
        set_req[REQ_ZERO] = (state.edge_sel[0] & s0_r)
            | ((~state.edge_sel[0] | state.edge_sel[1]) & s0_f);
        set_req[REQ_ONE] = p_fall[2];
        set_req[REQ_T0] = timer0_request_in;
        set_req[REQ_T1] = timer1_request_in;

        // AXI write path
        next_state.bvalid = state.bvalid & ~s_axi_bready_in;
        if (s_axi_awvalid_in && state.awready)
        begin
            next_state.aw_got = 1'b1;
            next_state.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && state.wready)
        begin
            next_state.w_got = 1'b1;
            next_state.wdata = s_axi_wdata_in;
            next_state.wen = s_axi_wstrb_in[0];
        end
        do_wr = state.aw_got & state.w_got & ~state.bvalid;
        if (do_wr)
        begin
            next_state.aw_got = 1'b0;
            next_state.w_got = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = RESP_OKAY;
            if (!(hit(state.aw_addr, IDX_FLAGS) || hit(state.aw_addr, IDX_MASK)
                || hit(state.aw_addr, IDX_PRIO) || hit(state.aw_addr, IDX_CONFIG)
                || hit(state.aw_addr, IDX_EVT_STAT) || hit(state.aw_addr, IDX_EVT_MASK)))
                next_state.bresp = RESP_SLVERR;
        end
        next_state.awready = ~next_state.aw_got & ~next_state.bvalid;
        next_state.wready = ~next_state.w_got & ~next_state.bvalid;

        // Grant handshake with the core
        if (state.pending && cpu_ack_in)
        begin
            next_state.req[state.src] = 1'b0;
            next_state.mask[GLOBAL_EN_BIT] = 1'b0;
        end
        next_state.cycle = state.pending & cpu_ack_in;
        if (iret_in)
            next_state.mask[GLOBAL_EN_BIT] = 1'b1;

        if (do_wr && state.wen)
        begin
            if (hit(state.aw_addr, IDX_FLAGS))
            begin
                next_state.req = state.wdata[5:0];
                next_state.edge_sel = state.wdata[7:6];
            end
            if (hit(state.aw_addr, IDX_MASK))
                next_state.mask = state.wdata[7:0];
            if (hit(state.aw_addr, IDX_PRIO))
                next_state.prio = state.wdata[5:0];
            if (hit(state.aw_addr, IDX_CONFIG))
                next_state.analog = state.wdata[0];
            if (hit(state.aw_addr, IDX_EVT_STAT))
                next_state.evt_stat = state.evt_stat & ~state.wdata[1:0];
            if (hit(state.aw_addr, IDX_EVT_MASK))
                next_state.evt_mask = state.wdata[1:0];
        end
        // Trigger wins over grant clear and software clear
        next_state.req = next_state.req | set_req;

        // Priority resolution; source latched even while globally disabled
        base = (state.prio[2:0] < 3'(N_SRC)) ? state.prio[2:0] : 3'h0;
        choice = pick(state.req & state.mask[5:0], base);
        next_state.pending = choice[3] & state.mask[GLOBAL_EN_BIT]
            & ~(state.pending & cpu_ack_in);
        if (choice[3])
            next_state.src = choice[2:0];

        // Upper register write protection
        blocked = ram_wr_req_in & state.mask[PROTECT_BIT]
            & (ram_wr_addr_in >= PROT_LO) & (ram_wr_addr_in <= PROT_HI);
        next_state.ram_allow = ram_wr_req_in & ~blocked;
        next_state.evt_stat = next_state.evt_stat
            | {blocked, state.pending & cpu_ack_in};
        next_state.irq = |(next_state.evt_stat & next_state.evt_mask);

        // AXI read path
        next_state.rvalid = state.rvalid & ~s_axi_rready_in;
        if (s_axi_arvalid_in && state.arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp = RESP_OKAY;
            next_state.rdata = 32'h0;
            if (hit(s_axi_araddr_in, IDX_FLAGS))
                next_state.rdata = {24'h0, state.edge_sel, 2'b00, state.req[3:0]}
                    | {26'h0, state.req[5:4], 4'h0};
            else if (hit(s_axi_araddr_in, IDX_MASK))
                next_state.rdata = {24'h0, state.mask};
            else if (hit(s_axi_araddr_in, IDX_PRIO))
                next_state.rdata = {26'h0, state.prio};
            else if (hit(s_axi_araddr_in, IDX_CONFIG))
                next_state.rdata = {31'h0, state.analog};
            else if (hit(s_axi_araddr_in, IDX_EVT_STAT))
                next_state.rdata = {30'h0, state.evt_stat};
            else if (hit(s_axi_araddr_in, IDX_EVT_MASK))
                next_state.rdata = {30'h0, state.evt_mask};
            else
                next_state.rresp = RESP_SLVERR;
        end
        next_state.arready = ~next_state.rvalid;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state <= '0;
            state.req <= FLAGS_RST;
            state.edge_sel <= EDGE_RST;
            state.mask <= MASK_RST;
            state.prio <= PRIO_RST;
        end
        else
            state <= next_state;
    end

    assign s_axi_awready_out = state.awready;
    assign s_axi_wready_out = state.wready;
    assign s_axi_bvalid_out = state.bvalid;
    assign s_axi_bresp_out = state.bresp;
    assign s_axi_arready_out = state.arready;
    assign s_axi_rvalid_out = state.rvalid;
    assign s_axi_rresp_out = state.rresp;
    assign s_axi_rdata_out = state.rdata;
    assign int_pending_out = state.pending;
    assign vector_addr_out = {4'h0, state.src, 1'b0};
    assign int_cycle_out = state.cycle;
    assign ram_wr_allow_out = state.ram_allow;
    assign irq_out = state.irq;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    a_prot_block: assert property (ram_wr_req_in && state.mask[PROTECT_BIT]
        && ram_wr_addr_in inside {[PROT_LO:PROT_HI]} |=> !ram_wr_allow_out)
        else $error("protected write allowed");
    a_prot_pass: assert property (ram_wr_req_in && !state.mask[PROTECT_BIT]
        |=> ram_wr_allow_out)
        else $error("unprotected write blocked");
    a_grant_cycle: assert property (int_pending_out && cpu_ack_in
        |=> int_cycle_out && !state.mask[GLOBAL_EN_BIT] && !int_pending_out)
        else $error("grant did not start machine cycle");
    a_vector_pair: assert property (int_pending_out
        |-> vector_addr_out[0] == 1'b0 && vector_addr_out <= 8'h0a)
        else $error("vector outside table");
    a_global_off: assert property (!state.mask[GLOBAL_EN_BIT] |=> !int_pending_out)
        else $error("pending while globally disabled");
    a_one_falling: assert property (!state.sync2_p[2] && state.prev_p[2]
        |=> state.req[REQ_ONE])
        else $error("falling edge on line three lost");
    a_timer_latch: assert property (timer0_request_in |=> state.req[REQ_T0])
        else $error("timer request not latched");
    a_irq_level: assert property (irq_out == |(state.evt_stat & state.evt_mask))
        else $error("interrupt output mismatch");

    c_grant: cover property (int_pending_out ##1 cpu_ack_in ##1 int_cycle_out);
    c_block: cover property (ram_wr_req_in && state.mask[PROTECT_BIT] ##1 !ram_wr_allow_out);
    c_both_edges: cover property (state.edge_sel == 2'h3 && state.req[REQ_TWO]);
endmodule

// ===== sim/core_seq_model.sv
// Core sequencer model: takes pending interrupts and returns from them
`timescale 1ns/1ps
module core_seq_model
(
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       resetn_in,
    // From interrupt unit
    input  wire logic       int_pending_in,
    input  wire logic       int_cycle_in,
    // Bench controls
    input  wire logic       ret_en_in,
    input  wire logic [3:0] ack_delay_in,
    // To interrupt unit
    output logic            cpu_ack_out,
    output logic            iret_out
);
    logic [3:0] wait_cnt;
    logic [2:0] ret_cnt;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cpu_ack_out <= 1'b0;
            iret_out    <= 1'b0;
            wait_cnt    <= 4'h0;
            ret_cnt     <= 3'h0;
        end
        else
        begin
            cpu_ack_out <= 1'b0;
            iret_out    <= 1'b0;
            // Take a pending request after a chosen delay
            if (int_pending_in && !cpu_ack_out)
            begin
                wait_cnt <= (wait_cnt >= ack_delay_in) ? 4'h0 : wait_cnt + 4'h1;
                cpu_ack_out <= (wait_cnt >= ack_delay_in);
            end
            else
                wait_cnt <= 4'h0;
            // Return from service re-enables interrupts
            if (int_cycle_in && ret_en_in)
                ret_cnt <= 3'h7;
            else if (ret_cnt != 3'h0)
            begin
                ret_cnt  <= ret_cnt - 3'h1;
                iret_out <= (ret_cnt == 3'h1);
            end
        end
    end
endmodule

// ===== sim/tb_six_source_vectored_interrupt_unit.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
module tb_six_source_vectored_interrupt_unit;
    import intc_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0;
    logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h00012d68;
    logic        awready, wready, bvalid, arready, rvalid, ack, iret, pend, icyc, irq, allow;
    logic [1:0]  bresp, rresp, resp;
    logic        l1 = 1'b1, l2 = 1'b1, l3 = 1'b1, cmp1 = 1'b1, cmp2 = 1'b1;
    logic        tm0 = 1'b0, tm1 = 1'b0, wr_req = 1'b0, ret_en = 1'b0, ack_d = 1'b0;
    logic [7:0]  vec, wr_addr = 8'h00, last_vec = 8'h00, rd;
    logic [3:0]  ack_dly = 4'h3;
    int          fail_count = 0, samples_checked = 0, grant_cnt = 0, cyc = 0;

    always #5 clk = ~clk;

    vectored_intc dut_u (.clk_sys_in(clk), .resetn_in(rstn),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .port3_line1_in(l1), .port3_line2_in(l2), .port3_line3_in(l3),
        .comparator_one_out_in(cmp1), .comparator_two_out_in(cmp2),
        .timer0_request_in(tm0), .timer1_request_in(tm1), .cpu_ack_in(ack), .iret_in(iret),
        .int_pending_out(pend), .vector_addr_out(vec), .int_cycle_out(icyc),
        .ram_wr_req_in(wr_req), .ram_wr_addr_in(wr_addr), .ram_wr_allow_out(allow),
        .irq_out(irq));

    core_seq_model core_u (.clk_sys_in(clk), .resetn_in(rstn), .int_pending_in(pend),
        .int_cycle_in(icyc), .ret_en_in(ret_en), .ack_delay_in(ack_dly),
        .cpu_ack_out(ack), .iret_out(iret));

    always @(posedge clk)
    begin
        if (ack_d === 1'b1)
            check("machine cycle", 1'b1, icyc);
        ack_d <= (ack === 1'b1 && pend === 1'b1);
        if (ack === 1'b1 && pend === 1'b1)
        begin
            grant_cnt <= grant_cnt + 1;
            last_vec  <= vec;
        end
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected flags after all three lines move one way under an edge code
    function automatic logic [7:0] edge_exp(input int c, input bit fall);
        logic r0, r2;
        r2 = fall ? (c != 2) : (c >= 2);
        r0 = fall ? (c != 1) : (c == 1 || c == 3);
        return {c[1:0], 3'h0, r2, fall, r0};
    endfunction

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    task automatic axw(input logic [7:0] idx, input logic [7:0] d);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
    endtask

    task automatic axr(input logic [7:0] idx);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata[7:0];
        resp = rresp;
    endtask

    task automatic wait_grant();
        int g;
        g = grant_cnt;
        while (grant_cnt == g) @(posedge clk);
    endtask

    task automatic guard(input logic [7:0] a, input bit prot);
        wr_req  <= 1'b1;
        wr_addr <= a;
        @(posedge clk);
        wr_req <= 1'b0;
        @(posedge clk);
        check("write allow", !(prot && a >= PROT_LO && a <= PROT_HI), allow);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        axr(IDX_FLAGS);
        check("flags reset", FLAGS_RST, rd);
        axr(IDX_MASK);
        check("mask reset", MASK_RST, rd);
        axr(8'h00);
        check("unmapped rresp", RESP_SLVERR, resp);
        axw(8'h00, 8'hff);
        check("unmapped bresp", RESP_SLVERR, resp);
        // Masked timer requests still latch
        tm0 <= 1'b1;
        tm1 <= 1'b1;
        @(posedge clk);
        tm0 <= 1'b0;
        tm1 <= 1'b0;
        repeat (3) @(posedge clk);
        axr(IDX_FLAGS);
        check("polled flags", 8'h30, rd);
        check("pending while masked", 1'b0, pend);
        axw(IDX_EVT_MASK, 8'h01);
        ret_en <= 1'b1;
        axw(IDX_MASK, 8'h90);
        wait_grant();
        check("timer vector", 8'h08, last_vec);
        @(posedge clk);
        axr(IDX_MASK);
        check("global off after grant", 8'h10, rd);
        repeat (12) @(posedge clk);
        axr(IDX_MASK);
        check("global after return", 8'h90, rd);
        axr(IDX_FLAGS);
        check("flags after grant", 8'h20, rd);
        check("grant event irq", 1'b1, irq);
        axw(IDX_EVT_STAT, 8'h01);
        repeat (2) @(posedge clk);
        check("irq cleared", 1'b0, irq);
        ret_en <= 1'b0;
        ack_dly <= 4'h0;
        axw(IDX_MASK, 8'h00);
        // Priority ranking from each start point
        for (int p = 0; p < 6; p++)
        begin
            axw(IDX_PRIO, p[7:0]);
            axw(IDX_FLAGS, 8'h3f);
            axw(IDX_MASK, 8'hbf);
            wait_grant();
            check("priority vector", 2 * p, last_vec);
            repeat (2) @(posedge clk);
            axr(IDX_FLAGS);
            check("flags after pick", 8'h3f & ~(8'h01 << p), rd);
        end
        axw(IDX_MASK, 8'h00);
        // Edge codes on both edges of the port lines
        for (int c = 0; c < 4; c++)
        begin
            axw(IDX_FLAGS, {c[1:0], 6'h00});
            {l1, l2, l3} <= 3'b000;
            repeat (6) @(posedge clk);
            axr(IDX_FLAGS);
            check("falling edge flags", edge_exp(c, 1'b1), rd);
            axw(IDX_FLAGS, {c[1:0], 6'h00});
            {l1, l2, l3} <= 3'b111;
            repeat (6) @(posedge clk);
            axr(IDX_FLAGS);
            check("rising edge flags", edge_exp(c, 1'b0), rd);
        end
        // Comparators in analog mode
        axw(IDX_CONFIG, 8'h01);
        repeat (4) @(posedge clk);
        axw(IDX_FLAGS, 8'hc0);
        {cmp1, cmp2} <= 2'b00;
        repeat (6) @(posedge clk);
        axr(IDX_FLAGS);
        check("comparator flags", 8'hc5, rd);
        // Write guard with boundary and random addresses
        axw(IDX_EVT_MASK, 8'h02);
        axw(IDX_MASK, 8'h40);
        for (int i = 0; i < 12; i++)
        begin
            guard(i == 0 ? 8'h80 : i == 1 ? 8'hef : i == 2 ? 8'h7f : i == 3 ? 8'hf0
                  : lfsr[7:0], 1'b1);
            lfsr = lfsr_next(lfsr);
        end
        repeat (2) @(posedge clk);
        check("blocked write irq", 1'b1, irq);
        axw(IDX_MASK, 8'h00);
        guard(8'h80, 1'b0);
        tally_and_finish();
    end
endmodule
